/* pkg/fscp_pkg.sv */
// Constants and types for the flash status/config protection block.
// Assumes a 100 MHz core clock and a serial host whose pins are sampled.
//
// Overview of operation
// - Origin bit 0 protects top, 1 bottom
// - Origin bit is OTP, never cleared
// - Origin bit changes only via write-status
// - Config bit7 dummy select, bit3 origin
// - Dummy select 1 gives 8, 0 gives 6
// - New config values take effect once written
// - Write-status updates status, and config only when a third byte is sent
// - Write-status sets or clears quad and lock
// - Write-status data leaves latch and busy bits alone
// - Write-status refused in hardware protected mode
// - Chip select off byte boundary rejects command
// - Busy set from chip select rise to end
// - Busy flag readable during register write
// - Write-enable latch cleared at write end
// - Lock 0 or protect pin high allows changes
// - Lock 1, pin low and quad 0 freezes protect bits
// - Program and erase blocked in protected region
// - Only protect pin high leaves hardware mode
// - Quad mode disables hardware protected mode
// - Busy reads 1 for any busy cycle
// - Lock bit non-volatile, default 0
`default_nettype none

package fscp_pkg;

    //------------------------------------------------------------------
    // Clock, commands, bit positions
    //------------------------------------------------------------------
    localparam int unsigned CLK_MHZ     = 100;
    localparam logic [7:0]  OP_WR_ENABLE  = 8'h06;
    localparam logic [7:0]  OP_WR_DISABLE = 8'h04;
    localparam logic [7:0]  OP_RDSTAT     = 8'h05;
    localparam logic [7:0]  OP_WR_STATUS  = 8'h01;
    localparam int unsigned SR_BUSY       = 0;
    localparam int unsigned SR_LATCH      = 1;
    localparam int unsigned SR_BP_LO      = 2;
    localparam int unsigned SR_QE         = 6;
    localparam int unsigned SR_LOCK       = 7;
    localparam int unsigned CFG_ORIGIN    = 3;
    localparam int unsigned CFG_DUMMY     = 7;
    localparam logic [3:0]  DUMMY_LONG    = 4'h8;
    localparam logic [3:0]  DUMMY_SHORT   = 4'h6;
    localparam logic [7:0]  SR_RESET      = 8'h00;
    localparam logic [7:0]  CFG_RESET     = 8'h00;

    //------------------------------------------------------------------
    // Types
    //------------------------------------------------------------------
    typedef struct packed {
        logic cs_b;
        logic sclk;
        logic si;
        logic wp_b;
    } fscp_pins_t;

    typedef enum logic {ST_IDLE, ST_WRITE} fscp_state_t;

endpackage : fscp_pkg

`default_nettype wire

/* hdl/fscp_core.sv */
// Status/configuration register write and protection logic.
// Assumes serial pins arrive asynchronously; rst_b_i acts as power-up.
`default_nettype none

module fscp_core #(
    parameter int unsigned WRITE_TIME_NS = 5000000,
    parameter int unsigned BLOCKS        = 64
) (
    input  wire logic                        clock_i,
    input  wire logic                        rst_b_i,
    input  wire logic                        cs_b_i,
    input  wire logic                        sclk_i,
    input  wire logic                        si_i,
    input  wire logic                        wp_b_i,
    input  wire logic                        array_busy_i,
    input  wire logic [$clog2(BLOCKS)-1:0]   pe_block_i,
    output logic                             so_o,
    output logic                             so_oe_o,
    output logic [7:0]                       status_o,
    output logic [7:0]                       config_o,
    output logic [3:0]                       dummy_cycles_o,
    output logic                             hw_protect_o,
    output logic                             pe_blocked_o
);
    import fscp_pkg::*;

    //------------------------------------------------------------------
    // Derived constants and elaboration checks
    //------------------------------------------------------------------
    localparam int unsigned BLK_W     = $clog2(BLOCKS);
    localparam int unsigned WR_CYCLES = (WRITE_TIME_NS * CLK_MHZ) / 1000;

    generate
        if (BLOCKS < 2 || (1 << BLK_W) != BLOCKS) begin : g_bad_blocks
            $error("BLOCKS must be a power of two of at least 2");
        end
        if (WR_CYCLES < 1) begin : g_bad_time
            $error("WRITE_TIME_NS gives less than one clock cycle");
        end
    endgenerate

    //------------------------------------------------------------------
    // Pin synchronisers and edge detection
    //------------------------------------------------------------------
    fscp_pins_t pins_raw;
    fscp_pins_t sync1_r;
    fscp_pins_t sync2_r;
    logic       sclk_d_r;
    logic       cs_d_r;

    assign pins_raw = '{cs_b: cs_b_i, sclk: sclk_i, si: si_i, wp_b: wp_b_i};

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sync1_r  <= '{cs_b: 1'b1, sclk: 1'b0, si: 1'b0, wp_b: 1'b1};
            sync2_r  <= '{cs_b: 1'b1, sclk: 1'b0, si: 1'b0, wp_b: 1'b1};
            sclk_d_r <= 1'b0;
            cs_d_r   <= 1'b1;
        end else begin
            sync1_r  <= pins_raw;
            sync2_r  <= sync1_r;
            sclk_d_r <= sync2_r.sclk;
            cs_d_r   <= sync2_r.cs_b;
        end
    end

    logic sel;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_rise;

    assign sel       = ~sync2_r.cs_b;
    assign sclk_rise = sync2_r.sclk & ~sclk_d_r;
    assign sclk_fall = ~sync2_r.sclk & sclk_d_r;
    assign cs_rise   = sync2_r.cs_b & ~cs_d_r;

    //------------------------------------------------------------------
    // State
    //------------------------------------------------------------------
    fscp_state_t  state_r,   state_nxt;
    logic [31:0]  timer_r,   timer_nxt;
    logic [7:0]   shift_r,   shift_nxt;
    logic [2:0]   bitcnt_r,  bitcnt_nxt;
    logic [1:0]   nbytes_r,  nbytes_nxt;
    logic [7:0]   opcode_r,  opcode_nxt;
    logic [7:0]   sr_new_r,  sr_new_nxt;
    logic [7:0]   cr_new_r,  cr_new_nxt;
    logic [7:0]   pend_sr_r, pend_sr_nxt;
    logic [7:0]   pend_cr_r, pend_cr_nxt;
    logic         pend_two_r, pend_two_nxt;
    logic         rd_act_r,  rd_act_nxt;
    logic [2:0]   rd_idx_r,  rd_idx_nxt;
    logic         so_r,      so_nxt;
    logic         so_oe_r,   so_oe_nxt;
    logic         latch_r,   latch_nxt;
    logic         lock_r,    lock_nxt;
    logic         qe_r,      qe_nxt;
    logic [3:0]   bp_r,      bp_nxt;
    logic         origin_r,  origin_nxt;
    logic         dsel_r,    dsel_nxt;
    logic [7:0]   status_r,  status_nxt;
    logic [7:0]   config_r,  config_nxt;
    logic [3:0]   dummy_r,   dummy_nxt;
    logic         hwp_r,     hwp_nxt;
    logic         blocked_r, blocked_nxt;

    logic         busy_now;
    logic         hwp_now;
    logic [7:0]   status_now;
    logic [7:0]   byte_in;
    logic         wr_status_ok;
    logic [BLK_W:0] region_sz;

    assign busy_now   = (state_r == ST_WRITE) | array_busy_i;
    assign hwp_now    = lock_r & ~sync2_r.wp_b & ~qe_r;
    assign status_now = {lock_r, qe_r, bp_r, latch_r, busy_now};
    assign byte_in    = {shift_r[6:0], sync2_r.si};
    // A write-status is taken only on a whole byte with a data byte
    assign wr_status_ok = cs_rise && opcode_r == OP_WR_STATUS
                        && bitcnt_r == 3'h0
                        && nbytes_r >= 2'h2 && latch_r && !hwp_now
                        && state_r == ST_IDLE && !array_busy_i;

    //------------------------------------------------------------------
    // Next-state logic
    //------------------------------------------------------------------
    always_comb begin
        state_nxt    = state_r;
        timer_nxt    = timer_r;
        shift_nxt    = shift_r;
        bitcnt_nxt   = bitcnt_r;
        nbytes_nxt   = nbytes_r;
        opcode_nxt   = opcode_r;
        sr_new_nxt   = sr_new_r;
        cr_new_nxt   = cr_new_r;
        pend_sr_nxt  = pend_sr_r;
        pend_cr_nxt  = pend_cr_r;
        pend_two_nxt = pend_two_r;
        rd_act_nxt   = rd_act_r;
        rd_idx_nxt   = rd_idx_r;
        so_nxt       = so_r;
        so_oe_nxt    = so_oe_r;
        latch_nxt    = latch_r;
        lock_nxt     = lock_r;
        qe_nxt       = qe_r;
        bp_nxt       = bp_r;
        origin_nxt   = origin_r;
        dsel_nxt     = dsel_r;

        // Serial shifter, sampled on rising serial clock
        if (sel) begin
            if (sclk_rise) begin
                shift_nxt  = byte_in;
                bitcnt_nxt = bitcnt_r + 3'h1;
                if (bitcnt_r == 3'h7) begin
                    case (nbytes_r)
                        2'h0: begin
                            opcode_nxt = byte_in;
                            rd_act_nxt = (byte_in == OP_RDSTAT);
                        end
                        2'h1: sr_new_nxt = byte_in;
                        2'h2: cr_new_nxt = byte_in;
                        default: ;
                    endcase
                    if (nbytes_r != 2'h3) begin
                        nbytes_nxt = nbytes_r + 2'h1;
                    end
                end
            end
            // Status read repeats while chip select stays low
            if (sclk_fall && rd_act_r) begin
                so_nxt     = status_now[3'h7 - rd_idx_r];
                so_oe_nxt  = 1'b1;
                rd_idx_nxt = rd_idx_r + 3'h1;
            end
        end else begin
            bitcnt_nxt = 3'h0;
            nbytes_nxt = 2'h0;
            rd_act_nxt = 1'b0;
            rd_idx_nxt = 3'h0;
            so_oe_nxt  = 1'b0;
        end

        // Commands act when chip select rises; busy ignores them
        if (cs_rise && state_r == ST_IDLE && !array_busy_i
            && bitcnt_r == 3'h0 && nbytes_r == 2'h1) begin
            if (opcode_r == OP_WR_ENABLE) begin
                latch_nxt = 1'b1;
            end else if (opcode_r == OP_WR_DISABLE) begin
                latch_nxt = 1'b0;
            end
        end

        case (state_r)
            ST_IDLE: begin
                if (wr_status_ok) begin
                    pend_sr_nxt  = sr_new_r;
                    pend_cr_nxt  = cr_new_r;
                    pend_two_nxt = (nbytes_r == 2'h3);
                    timer_nxt    = WR_CYCLES - 1;
                    state_nxt    = ST_WRITE;
                end
            end
            ST_WRITE: begin
                if (timer_r != 32'h0) begin
                    timer_nxt = timer_r - 32'h1;
                end else begin
                    // Latch and busy bits are not taken from the data
                    lock_nxt  = pend_sr_r[SR_LOCK];
                    qe_nxt    = pend_sr_r[SR_QE];
                    bp_nxt    = pend_sr_r[SR_BP_LO +: 4];
                    if (pend_two_r) begin
                        origin_nxt = origin_r
                                     | pend_cr_r[CFG_ORIGIN];
                        dsel_nxt   = pend_cr_r[CFG_DUMMY];
                    end
                    latch_nxt = 1'b0;
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    //------------------------------------------------------------------
    // Protected region and registered outputs
    //------------------------------------------------------------------
    always_comb begin
        if (bp_r == 4'h0) begin
            region_sz = '0;
        end else if (32'(bp_r) > BLK_W) begin
            region_sz = (BLK_W+1)'(BLOCKS);
        end else begin
            region_sz = (BLK_W+1)'(1) << (bp_r - 4'h1);
        end
        // Origin 0 counts down from the top, 1 up from the bottom
        if (origin_r) begin
            blocked_nxt = {1'b0, pe_block_i} < region_sz;
        end else begin
            blocked_nxt = {1'b0, pe_block_i} >=
                          (BLK_W+1)'(BLOCKS) - region_sz;
        end
        status_nxt = status_now;
        config_nxt = CFG_RESET;
        config_nxt[CFG_DUMMY]  = dsel_r;
        config_nxt[CFG_ORIGIN] = origin_r;
        dummy_nxt  = dsel_r ? DUMMY_LONG : DUMMY_SHORT;
        hwp_nxt    = hwp_now;
    end

    //------------------------------------------------------------------
    // Registers
    //------------------------------------------------------------------
    // Non-volatile bits are modelled as flops cleared at power-up
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_r    <= ST_IDLE;
            timer_r    <= 32'h0;
            shift_r    <= 8'h00;
            bitcnt_r   <= 3'h0;
            nbytes_r   <= 2'h0;
            opcode_r   <= 8'h00;
            sr_new_r   <= 8'h00;
            cr_new_r   <= 8'h00;
            pend_sr_r  <= 8'h00;
            pend_cr_r  <= 8'h00;
            pend_two_r <= 1'b0;
            rd_act_r   <= 1'b0;
            rd_idx_r   <= 3'h0;
            so_r       <= 1'b0;
            so_oe_r    <= 1'b0;
            latch_r    <= 1'b0;
            lock_r     <= SR_RESET[SR_LOCK];
            qe_r       <= SR_RESET[SR_QE];
            bp_r       <= SR_RESET[SR_BP_LO +: 4];
            origin_r   <= CFG_RESET[CFG_ORIGIN];
            dsel_r     <= CFG_RESET[CFG_DUMMY];
            status_r   <= SR_RESET;
            config_r   <= CFG_RESET;
            dummy_r    <= DUMMY_SHORT;
            hwp_r      <= 1'b0;
            blocked_r  <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            timer_r    <= timer_nxt;
            shift_r    <= shift_nxt;
            bitcnt_r   <= bitcnt_nxt;
            nbytes_r   <= nbytes_nxt;
            opcode_r   <= opcode_nxt;
            sr_new_r   <= sr_new_nxt;
            cr_new_r   <= cr_new_nxt;
            pend_sr_r  <= pend_sr_nxt;
            pend_cr_r  <= pend_cr_nxt;
            pend_two_r <= pend_two_nxt;
            rd_act_r   <= rd_act_nxt;
            rd_idx_r   <= rd_idx_nxt;
            so_r       <= so_nxt;
            so_oe_r    <= so_oe_nxt;
            latch_r    <= latch_nxt;
            lock_r     <= lock_nxt;
            qe_r       <= qe_nxt;
            bp_r       <= bp_nxt;
            origin_r   <= origin_nxt;
            dsel_r     <= dsel_nxt;
            status_r   <= status_nxt;
            config_r   <= config_nxt;
            dummy_r    <= dummy_nxt;
            hwp_r      <= hwp_nxt;
            blocked_r  <= blocked_nxt;
        end
    end

    assign so_o           = so_r;
    assign so_oe_o        = so_oe_r;
    assign status_o       = status_r;
    assign config_o       = config_r;
    assign dummy_cycles_o = dummy_r;
    assign hw_protect_o   = hwp_r;
    assign pe_blocked_o   = blocked_r;

    //------------------------------------------------------------------
    // Assertions
    //------------------------------------------------------------------
    sequence s_status_busy;
        (state_r == ST_WRITE) ##1 status_r[SR_BUSY];
    endsequence

    sequence s_write_end;
        (state_r == ST_WRITE) && (timer_r == 32'h0);
    endsequence

    status_busy_a: assert property (
        @(posedge clock_i) disable iff (!rst_b_i)
        wr_status_ok |=> s_status_busy)
        else $error("write-status did not raise busy");

    write_hold_a: assert property (
        @(posedge clock_i) disable iff (!rst_b_i)
        (state_r == ST_WRITE && timer_r != 32'h0) |=> state_r == ST_WRITE)
        else $error("register write ended early");

    write_end_wel_a: assert property (
        @(posedge clock_i) disable iff (!rst_b_i)
        s_write_end |=> (!latch_r && state_r == ST_IDLE))
        else $error("latch not cleared at write end");

    hw_refuse_a: assert property (
        @(posedge clock_i) disable iff (!rst_b_i)
        (cs_rise && opcode_r == OP_WR_STATUS && hwp_now
         && state_r == ST_IDLE)
        |=> state_r == ST_IDLE)
        else $error("write-status taken in hardware protection");

    boundary_reject_a: assert property (
        @(posedge clock_i) disable iff (!rst_b_i)
        (cs_rise && bitcnt_r != 3'h0 && state_r == ST_IDLE)
        |=> state_r == ST_IDLE)
        else $error("write-status taken off byte boundary");

    origin_otp_a: assert property (
        @(posedge clock_i) disable iff (!rst_b_i)
        origin_r |=> origin_r)
        else $error("origin bit cleared");

    hw_freeze_a: assert property (
        @(posedge clock_i) disable iff (!rst_b_i)
        (hwp_now && state_r == ST_IDLE) |=> ##1 $stable({lock_r, bp_r}))
        else $error("protect bits changed in hardware protection");

    dummy_count_a: assert property (
        @(posedge clock_i) disable iff (!rst_b_i)
        ##1 dummy_r == ($past(dsel_r) ? DUMMY_LONG : DUMMY_SHORT))
        else $error("dummy count does not follow select bit");

    quad_no_hpm_a: assert property (
        @(posedge clock_i) disable iff (!rst_b_i)
        qe_r |=> !hw_protect_o)
        else $error("hardware protection active in quad mode");

endmodule : fscp_core

`default_nettype wire

/* verification/fscp_host_model.sv */
// Serial host model: frames commands on chip select, serial clock and data.
// Assumes a 100 MHz core clock; the serial clock idles low between frames.
`default_nettype none

module fscp_host_model (
    input  wire logic clock_i,
    input  wire logic so_i,
    output var  logic cs_b_o,
    output var  logic sclk_o,
    output var  logic si_o
);
    timeunit 1ns;
    timeprecision 100ps;

    //------------------------------------------------------------------
    // Pin state
    //------------------------------------------------------------------
    initial begin
        cs_b_o = 1'b1;
        sclk_o = 1'b0;
        si_o   = 1'b1;
    end

    //------------------------------------------------------------------
    // One frame: n bits out MSB first, then nrd bits read back
    //------------------------------------------------------------------
    // Half periods of six core cycles give a serial clock period of 120 ns
    task automatic xfer(input logic [23:0] d, input int n, input int nrd,
                        output logic [7:0] v);
        int i;
        v = 8'h00;
        @(negedge clock_i);
        cs_b_o = 1'b0;
        for (i = 0; i < n + nrd; i++) begin
            if (i < n) si_o = d[n-1-i];
            else si_o = ~si_o;
            repeat (6) @(negedge clock_i);
            if (i >= n) v = {v[6:0], so_i};
            sclk_o = 1'b1;
            repeat (6) @(negedge clock_i);
            sclk_o = 1'b0;
        end
        repeat (6) @(negedge clock_i);
        // Released data line shows the inverse so a stale bit cannot pass
        cs_b_o = 1'b1;
        si_o = ~si_o;
        repeat (6) @(negedge clock_i);
    endtask : xfer

endmodule : fscp_host_model

`default_nettype wire

/* verification/flash_status_config_protect_tb_top.sv */
// Testbench for the status/config write and protection core.
// Assumes the serial host model drives the pins; core inputs change at negedge.
`default_nettype none

module flash_status_config_protect_tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    //------------------------------------------------------------------
    // Signals and instances
    //------------------------------------------------------------------
    localparam int unsigned BLOCKS = 64;
    logic                      clock_i;
    logic                      rst_b_i;
    logic                      cs_b, sclk, si, so, so_oe;
    logic                      wp_b_i;
    logic                      array_busy_i;
    logic [$clog2(BLOCKS)-1:0] pe_block_i;
    logic [7:0]                status_o, config_o;
    logic [3:0]                dummy_cycles_o;
    logic                      hw_protect_o, pe_blocked_o;
    int                        n_errors = 0;
    int                        samples_checked = 0;

    // Short write time keeps the self-timed cycle at 20 core cycles
    fscp_core #(.WRITE_TIME_NS(200), .BLOCKS(BLOCKS)) fscp_core_inst (
        .clock_i(clock_i), .rst_b_i(rst_b_i), .cs_b_i(cs_b),
        .sclk_i(sclk), .si_i(si), .wp_b_i(wp_b_i),
        .array_busy_i(array_busy_i), .pe_block_i(pe_block_i),
        .so_o(so), .so_oe_o(so_oe), .status_o(status_o),
        .config_o(config_o), .dummy_cycles_o(dummy_cycles_o),
        .hw_protect_o(hw_protect_o), .pe_blocked_o(pe_blocked_o));

    fscp_host_model fscp_host_model_inst (
        .clock_i(clock_i), .so_i(so), .cs_b_o(cs_b), .sclk_o(sclk),
        .si_o(si));

    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end

    //------------------------------------------------------------------
    // Helpers
    //------------------------------------------------------------------
    task automatic check(input logic [7:0] got, input logic [7:0] exp,
                         input string what);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check

    task automatic report_and_stop;
        $display("errors=%0d checks=%0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : report_and_stop

    task automatic set_latch;
        logic [7:0] v;
        fscp_host_model_inst.xfer(24'h000006, 8, 0, v);
    endtask : set_latch

    // Write frame d of n bits after a write enable; ok says if it runs
    task automatic wr_status(input logic [23:0] d, input int n,
                             input logic ok);
        logic [7:0] v;
        int         i;
        set_latch();
        fscp_host_model_inst.xfer(d, n, 0, v);
        check({7'h00, status_o[0]}, {7'h00, ok}, "busy start");
        repeat (8) @(negedge clock_i);
        check({7'h00, status_o[0]}, {7'h00, ok}, "busy held");
        i = 0;
        while (status_o[0] !== 1'b0 && i < 40) begin
            @(negedge clock_i);
            i++;
        end
        check(i[7:0] == 8'd40, 8'h00, "busy stuck");
        @(negedge clock_i);
    endtask : wr_status

    task automatic pe_check(input logic [5:0] blk, input logic exp);
        @(negedge clock_i);
        pe_block_i = blk;
        repeat (3) @(negedge clock_i);
        check({7'h00, pe_blocked_o}, {7'h00, exp}, "blocked");
    endtask : pe_check

    task automatic set_wp(input logic lvl);
        @(negedge clock_i);
        wp_b_i = lvl;
        repeat (6) @(negedge clock_i);
    endtask : set_wp

    //------------------------------------------------------------------
    // Scenarios
    //------------------------------------------------------------------
    task automatic t_reset;
        check(status_o, 8'h00, "reset status");
        check(config_o, 8'h00, "reset config");
        check({4'h0, dummy_cycles_o}, 8'h06, "reset dummy");
        $display("t_reset done");
    endtask : t_reset

    task automatic t_no_latch;
        logic [7:0] v;
        fscp_host_model_inst.xfer(24'h013cff, 24, 0, v);
        repeat (4) @(negedge clock_i);
        check(status_o, 8'h00, "no latch");
        $display("t_no_latch done");
    endtask : t_no_latch

    task automatic t_status_only;
        set_latch();
        check(status_o, 8'h02, "latch set");
        wr_status(24'h000147, 16, 1'b1);
        check(status_o, 8'h44, "status only");
        check(config_o, 8'h00, "config kept");
        pe_check(6'd63, 1'b1);
        pe_check(6'd0, 1'b0);
        $display("t_status_only done");
    endtask : t_status_only

    task automatic t_both;
        wr_status(24'h017cff, 24, 1'b1);
        check(status_o, 8'h7c, "both status");
        check(config_o, 8'h88, "both config");
        check({4'h0, dummy_cycles_o}, 8'h08, "dummy long");
        pe_check(6'd0, 1'b1);
        $display("t_both done");
    endtask : t_both

    task automatic t_misframe;
        // Opcode, one zero data byte, then four stray bits
        wr_status(24'h001000, 20, 1'b0);
        check(status_o, 8'h7e, "misframed");
        $display("t_misframe done");
    endtask : t_misframe

    task automatic t_protect;
        wr_status(24'h018400, 24, 1'b1);
        check(status_o, 8'h84, "lock set");
        check(config_o, 8'h08, "origin kept");
        check({4'h0, dummy_cycles_o}, 8'h06, "dummy short");
        pe_check(6'd0, 1'b1);
        pe_check(6'd1, 1'b0);
        set_wp(1'b0);
        check({7'h00, hw_protect_o}, 8'h01, "hw mode");
        wr_status(24'h010000, 24, 1'b0);
        check(status_o, 8'h86, "hw refused");
        set_wp(1'b1);
        check({7'h00, hw_protect_o}, 8'h00, "hw exit");
        wr_status(24'h01c400, 24, 1'b1);
        check(status_o, 8'hc4, "lock quad");
        set_wp(1'b0);
        check({7'h00, hw_protect_o}, 8'h00, "quad no hw");
        set_wp(1'b1);
        $display("t_protect done");
    endtask : t_protect

    task automatic t_read_busy;
        logic [7:0] v;
        @(negedge clock_i);
        array_busy_i = 1'b1;
        fscp_host_model_inst.xfer(24'h000005, 8, 8, v);
        check(v, 8'hc5, "read busy");
        check({7'h00, so_oe}, 8'h00, "data line released");
        @(negedge clock_i);
        array_busy_i = 1'b0;
        repeat (3) @(negedge clock_i);
        check(status_o, 8'hc4, "busy gone");
        $display("t_read_busy done");
    endtask : t_read_busy

    //------------------------------------------------------------------
    // Main sequence and watchdog
    //------------------------------------------------------------------
    initial begin
        rst_b_i = 1'b0;
        wp_b_i = 1'b1;
        array_busy_i = 1'b0;
        pe_block_i = '0;
        repeat (12) @(negedge clock_i);
        rst_b_i = 1'b1;
        repeat (4) @(negedge clock_i);
        t_reset();
        t_no_latch();
        t_status_only();
        t_both();
        t_misframe();
        t_protect();
        t_read_busy();
        report_and_stop();
    end

    // Whole run needs about 3100 core cycles
    initial begin
        #500us;
        n_errors++;
        $display("BAD t=%0t watchdog expired", $time);
        report_and_stop();
    end

endmodule : flash_status_config_protect_tb_top

`default_nettype wire
